/* rtl/dl_consts.svh */
`ifndef DL_CONSTS_SVH
`define DL_CONSTS_SVH
// Target register addresses inside the link address window
`define DL_TGT_MODE_ADDR   8'hf0
`define DL_TGT_IRQCLR_ADDR 8'hf1
// Width of the ack timeout counter in bus clocks
`define DL_TO_W            16
// Width of the link clock divider
`define DL_DIV_W           4
`endif

/* rtl/dl_pkg.sv */
package dl_pkg;
  // Initiator transaction states
  typedef enum logic [1:0] {
    DL_I_OFF  = 2'b00,
    DL_I_IDLE = 2'b01,
    DL_I_WAIT = 2'b10,
    DL_I_REL  = 2'b11
  } dl_init_state_t;

  // Two parity bits: even bit positions and odd bit positions
  function automatic logic [1:0] dl_parity(input logic [7:0] d);
    dl_parity = {^{d[7], d[5], d[3], d[1]}, ^{d[6], d[4], d[2], d[0]}};
  endfunction
endpackage

/* rtl/dl_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dl_link_if;
  logic       linkClk;
  logic       reqValid;
  logic       reqWrite;
  logic [7:0] reqAddr;
  logic [7:0] reqData;
  logic       ackValid;
  logic [7:0] ackData;
  logic [1:0] ackParity;
  logic       ackErr;
  logic       irqLine;
  modport init (output linkClk, reqValid, reqWrite, reqAddr, reqData,
                input ackValid, ackData, ackParity, ackErr, irqLine);
  modport tgt  (input linkClk, reqValid, reqWrite, reqAddr, reqData,
                output ackValid, ackData, ackParity, ackErr, irqLine);
endinterface
`default_nettype wire

/* rtl/dl_target.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dl_consts.svh"
module dl_target
(
  // Link side
  dl_link_if.tgt    link,
  // User side
  input  wire logic tgtNoAck,
  input  wire logic tgtErrInject,
  input  wire logic tgtParFlip,
  input  wire logic tgtIrqRaise,
  input  wire logic tgtWake,
  output logic      tgtLowPower,
  output logic [7:0] tgtMode
);
  import dl_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic       reqS1;
    logic       reqS2;
    logic       stage;
    logic       ack;
    logic [7:0] data;
    logic [1:0] par;
    logic       err;
    logic       irq;
    logic       armed;
    logic       lowPower;
    logic [7:0] mode;
    logic [4:0] usrS1;
    logic [4:0] usrS2;
  } dl_tgt_regs_t;

  // No reset pin: flops start cleared so the irq and power state are known
  dl_tgt_regs_t r_reg = '0;
  dl_tgt_regs_t r_next;
  logic [7:0]   mem [0:255];
  logic [7:0]   rdByte;
  logic         memWe;

  assign rdByte = mem[link.reqAddr];

  // Request is decoded two link clocks after it is seen, ack follows one later
  always_comb
  begin
    r_next = r_reg;
    memWe = 1'b0;
    r_next.reqS1 = link.reqValid;
    r_next.reqS2 = r_reg.reqS1;
    r_next.usrS1 = {tgtNoAck, tgtErrInject, tgtParFlip, tgtIrqRaise, tgtWake};
    r_next.usrS2 = r_reg.usrS1;
    if (r_reg.reqS2 && !r_reg.ack && !r_reg.usrS2[4])
    begin
      if (!r_reg.stage)
      begin
        r_next.stage = 1'b1;
        r_next.data = link.reqWrite ? link.reqData : rdByte;
        r_next.par = dl_parity(link.reqWrite ? link.reqData : rdByte) ^ {2{r_reg.usrS2[2]}};
        r_next.err = r_reg.usrS2[3];
        if (link.reqWrite)
        begin
          memWe = 1'b1;
          if (link.reqAddr == `DL_TGT_MODE_ADDR)
          begin
            r_next.mode = link.reqData;
            r_next.armed = 1'b1;
          end
          if (link.reqAddr == `DL_TGT_IRQCLR_ADDR)
            r_next.irq = 1'b0;
        end
      end
      else
        r_next.ack = 1'b1;
    end
    else if (!r_reg.reqS2)
    begin
      r_next.ack = 1'b0;
      r_next.stage = 1'b0;
      if (r_reg.armed && !r_reg.ack)
        r_next.lowPower = 1'b1;
    end
    if (r_reg.usrS2[0] && r_reg.lowPower)
    begin
      r_next.lowPower = 1'b0;
      r_next.armed = 1'b0;
      r_next.irq = 1'b1;
    end
    // Raise wins over a clear in the same cycle
    if (r_reg.usrS2[1])
      r_next.irq = 1'b1;
  end

  // Registers on the link clock; the memory holds no reset
  always_ff @(posedge link.linkClk)
  begin
    r_reg <= r_next;
    if (memWe)
      mem[link.reqAddr] <= link.reqData;
  end

  assign link.ackValid  = r_reg.ack;
  assign link.ackData   = r_reg.data;
  assign link.ackParity = r_reg.par;
  assign link.ackErr    = r_reg.err;
  assign link.irqLine   = r_reg.irq;
  assign tgtLowPower    = r_reg.lowPower;
  assign tgtMode        = r_reg.mode;
endmodule
`default_nettype wire

/* rtl/dl_initiator.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dl_consts.svh"
module dl_initiator
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Link
  dl_link_if.init                    link,
  // Configuration
  input  wire logic                  linkEnable,
  input  wire logic                  linkIrqEnable,
  input  wire logic                  stopClockOff,
  input  wire logic [`DL_DIV_W-1:0]  clkDiv,
  input  wire logic [`DL_TO_W-1:0]   ackTimeoutValue,
  // CPU stop request
  input  wire logic                  stopReq,
  output logic                       stopped,
  // Transaction request
  input  wire logic                  userReqValid,
  input  wire logic                  userWrite,
  input  wire logic [7:0]            userAddr,
  input  wire logic [7:0]            userWData,
  output logic                       userReady,
  // Transaction answer
  output logic                       userDone,
  output logic                       userDoneErr,
  output logic [7:0]                 userRdData,
  // Status
  input  wire logic                  errClear,
  output logic                       globalErrorFlag,
  output logic                       timeoutErrorFlag,
  output logic                       parityErrorFlag,
  output logic                       targetErrorFlag,
  output logic                       cancelFlag,
  output logic [1:0]                 receivedParity,
  output logic                       targetIrqLevel,
  output logic                       gpioMode,
  // Interrupts
  output logic                       targetIrqSignal,
  output logic                       linkErrorIrq
);
  import dl_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    dl_init_state_t       st;
    logic [`DL_DIV_W-1:0] divCnt;
    logic                 linkClk;
    logic [`DL_TO_W-1:0]  toCnt;
    logic                 reqValid;
    logic                 reqWrite;
    logic [7:0]           reqAddr;
    logic [7:0]           reqData;
    logic                 pendValid;
    logic                 pendWrite;
    logic [7:0]           pendAddr;
    logic [7:0]           pendData;
    logic                 gErr;
    logic                 toErr;
    logic                 parErr;
    logic                 tErr;
    logic                 cancel;
    logic [1:0]           rxPar;
    logic [7:0]           rdData;
    logic                 done;
    logic                 doneErr;
    logic                 ready;
    logic                 stopped;
    logic                 gpio;
    logic                 extIrq;
    logic                 errIrq;
    logic                 irqLevel;
    logic                 ackS1;
    logic                 ackS2;
    logic                 irqS1;
    logic                 irqS2;
  } dl_init_regs_t;

  dl_init_regs_t r_reg;
  dl_init_regs_t r_next;
  logic          halt;
  logic [1:0]    expPar;
  logic          parBad;
  logic          anyErr;

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.doneErr = 1'b0;
    expPar = dl_parity(r_reg.reqWrite ? r_reg.reqData : link.ackData);
    parBad = (expPar != link.ackParity);
    anyErr = parBad || link.ackErr;
    // Ack and irq come from the link clock domain: two flops first
    r_next.ackS1 = link.ackValid;
    r_next.ackS2 = r_reg.ackS1;
    r_next.irqS1 = link.irqLine;
    r_next.irqS2 = r_reg.irqS1;
    r_next.irqLevel = r_reg.irqS2;
    r_next.gpio = !linkEnable;

    if (errClear)
    begin
      r_next.gErr = 1'b0;
      r_next.toErr = 1'b0;
      r_next.parErr = 1'b0;
      r_next.tErr = 1'b0;
      r_next.cancel = 1'b0;
    end

    // Accept a request into the one-slot queue
    if (userReqValid && r_reg.ready)
    begin
      if (r_reg.gErr)
      begin
        r_next.done = 1'b1;
        r_next.doneErr = 1'b1;
      end
      else
      begin
        r_next.pendValid = 1'b1;
        r_next.pendWrite = userWrite;
        r_next.pendAddr = userAddr;
        r_next.pendData = userWData;
      end
    end

    // Transaction sequencing
    case (r_reg.st)
      DL_I_OFF:
      begin
        if (linkEnable)
          r_next.st = DL_I_IDLE;
      end
      DL_I_IDLE:
      begin
        if (r_reg.pendValid && !r_reg.gErr)
        begin
          r_next.reqValid = 1'b1;
          r_next.reqWrite = r_reg.pendWrite;
          r_next.reqAddr = r_reg.pendAddr;
          r_next.reqData = r_reg.pendData;
          r_next.pendValid = r_next.pendValid && userReqValid && r_reg.ready;
          r_next.toCnt = '0;
          r_next.st = DL_I_WAIT;
        end
      end
      DL_I_WAIT:
      begin
        r_next.toCnt = r_reg.toCnt + 1'b1;
        if (r_reg.ackS2)
        begin
          r_next.reqValid = 1'b0;
          r_next.done = 1'b1;
          r_next.doneErr = anyErr;
          r_next.st = DL_I_REL;
          if (!r_reg.gErr)
          begin
            r_next.rxPar = link.ackParity;
            r_next.rdData = link.ackData;
          end
          if (parBad)
          begin
            r_next.gErr = 1'b1;
            r_next.parErr = 1'b1;
          end
          if (link.ackErr)
          begin
            r_next.gErr = 1'b1;
            r_next.tErr = 1'b1;
          end
          // cancel queued transfer
          // A request taken in this same cycle is dropped too, else it would sit stuck
          if (anyErr && r_next.pendValid)
          begin
            r_next.pendValid = 1'b0;
            r_next.cancel = 1'b1;
          end
        end
        else if (r_reg.toCnt >= ackTimeoutValue)
        begin
          r_next.reqValid = 1'b0;
          r_next.gErr = 1'b1;
          r_next.toErr = 1'b1;
          r_next.done = 1'b1;
          r_next.doneErr = 1'b1;
          r_next.st = DL_I_REL;
          if (r_next.pendValid)
          begin
            r_next.pendValid = 1'b0;
            r_next.cancel = 1'b1;
          end
        end
      end
      DL_I_REL:
      begin
        // Four-phase: wait for the target to drop its ack
        if (!r_reg.ackS2)
          r_next.st = DL_I_IDLE;
      end
      default:
        r_next.st = DL_I_OFF;
    endcase

    if (!linkEnable)
    begin
      r_next.st = DL_I_OFF;
      r_next.reqValid = 1'b0;
      r_next.pendValid = 1'b0;
    end

    r_next.stopped = stopReq && linkEnable && !r_reg.pendValid
                     && (r_reg.st == DL_I_IDLE);
    // New work is refused while a stop is requested
    r_next.ready = linkEnable && !stopReq && !r_next.pendValid;

    halt = !linkEnable || (r_reg.stopped && stopClockOff && !r_reg.linkClk);
    if (halt)
    begin
      r_next.divCnt = '0;
      r_next.linkClk = 1'b0;
    end
    else if (r_reg.divCnt >= clkDiv)
    begin
      r_next.divCnt = '0;
      r_next.linkClk = !r_reg.linkClk;
    end
    else
      r_next.divCnt = r_reg.divCnt + 1'b1;

    r_next.extIrq = linkIrqEnable && linkEnable && r_reg.irqS2;
    r_next.errIrq = linkIrqEnable && linkEnable && r_next.gErr;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.gpio <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // ****************************************************
  // Outputs, all straight from flops
  // ****************************************************
  assign link.linkClk     = r_reg.linkClk;
  assign link.reqValid    = r_reg.reqValid;
  assign link.reqWrite    = r_reg.reqWrite;
  assign link.reqAddr     = r_reg.reqAddr;
  assign link.reqData     = r_reg.reqData;
  assign stopped          = r_reg.stopped;
  assign userReady        = r_reg.ready;
  assign userDone         = r_reg.done;
  assign userDoneErr      = r_reg.doneErr;
  assign userRdData       = r_reg.rdData;
  assign globalErrorFlag  = r_reg.gErr;
  assign timeoutErrorFlag = r_reg.toErr;
  assign parityErrorFlag  = r_reg.parErr;
  assign targetErrorFlag  = r_reg.tErr;
  assign cancelFlag       = r_reg.cancel;
  assign receivedParity   = r_reg.rxPar;
  assign targetIrqLevel   = r_reg.irqLevel;
  assign gpioMode         = r_reg.gpio;
  assign targetIrqSignal  = r_reg.extIrq;
  assign linkErrorIrq     = r_reg.errIrq;
endmodule
`default_nettype wire

/* bench/dl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module dl_chk
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Link wires
  input wire logic       linkClk,
  input wire logic       reqValid,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  input wire logic       ackValid,
  input wire logic [7:0] ackData,
  input wire logic [1:0] ackParity,
  input wire logic       irqLine,
  // Initiator side
  input wire logic       linkEnable,
  input wire logic       linkIrqEnable,
  input wire logic       stopClockOff,
  input wire logic       errClear,
  input wire logic       userDone,
  input wire logic       userDoneErr,
  input wire logic       stopped,
  input wire logic       globalErrorFlag,
  input wire logic       timeoutErrorFlag,
  input wire logic       parityErrorFlag,
  input wire logic       targetErrorFlag,
  input wire logic [1:0] receivedParity,
  input wire logic       targetIrqLevel,
  input wire logic       targetIrqSignal,
  input wire logic       linkErrorIrq,
  input wire logic       gpioMode
);
  // ****************
  // Link properties
  // ****************
  // Everything is judged on the bus clock; the link wires are slow enough
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_causeGlobal;
    (timeoutErrorFlag || parityErrorFlag || targetErrorFlag) |-> globalErrorFlag;
  endproperty
  a_causeGlobal: assert property (p_causeGlobal) else $error("cause flag without global flag");
  property p_reqHold;
    reqValid && $past(reqValid) |-> $stable(reqAddr) && $stable(reqData);
  endproperty
  a_reqHold: assert property (p_reqHold) else $error("request changed while valid");
  property p_ackHold;
    ackValid && $past(ackValid) |-> $stable(ackData) && $stable(ackParity);
  endproperty
  a_ackHold: assert property (p_ackHold) else $error("answer changed while valid");
  property p_parHeld;
    globalErrorFlag && !errClear |=> globalErrorFlag && $stable(receivedParity);
  endproperty
  a_parHeld: assert property (p_parHeld) else $error("error state not held");
  property p_offPins;
    !linkEnable [*2] |-> gpioMode && !reqValid && !linkClk;
  endproperty
  a_offPins: assert property (p_offPins) else $error("link pins active while disabled");
  property p_highPhase;
    $rose(linkClk) |=> linkClk;
  endproperty
  a_highPhase: assert property (p_highPhase) else $error("link clock high phase cut short");
  property p_stopLow;
    (stopped && stopClockOff) [*8] |-> !linkClk;
  endproperty
  a_stopLow: assert property (p_stopLow) else $error("link clock not low in stop");
  property p_irqGate;
    !linkIrqEnable [*2] |-> !targetIrqSignal && !linkErrorIrq;
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("interrupt while disabled");
  property p_errIrq;
    (globalErrorFlag && linkIrqEnable && linkEnable) [*2] |-> linkErrorIrq;
  endproperty
  a_errIrq: assert property (p_errIrq) else $error("error interrupt missing");
  property p_irqLevel;
    $stable(irqLine) [*5] |-> targetIrqLevel == irqLine;
  endproperty
  a_irqLevel: assert property (p_irqLevel) else $error("irq status does not follow pin");
  property p_clear;
    errClear |=> !globalErrorFlag || userDone;
  endproperty
  a_clear: assert property (p_clear) else $error("error clear ignored");
  property p_idleRepl;
    globalErrorFlag && $past(globalErrorFlag) |-> !$rose(reqValid) && (!userDone || userDoneErr);
  endproperty
  a_idleRepl: assert property (p_idleRepl) else $error("transfer sent while in error");
  c_timeout: cover property ($rose(timeoutErrorFlag));
  c_stop: cover property (stopped && stopClockOff);
  c_irq: cover property (targetIrqSignal);
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dl_consts.svh"
module tb_top;
  // ***************
  // Bench plumbing
  // ***************
  logic clk, rst, linkEnable, linkIrqEnable, stopClockOff, stopReq, userReqValid, userWrite, errClear;
  logic tgtNoAck, tgtErrInject, tgtParFlip, tgtIrqRaise, tgtWake, tgtLowPower, stopped, userReady;
  logic userDone, userDoneErr, globalErrorFlag, timeoutErrorFlag, parityErrorFlag, targetErrorFlag;
  logic cancelFlag, targetIrqLevel, gpioMode, targetIrqSignal, linkErrorIrq, dErr;
  logic [`DL_DIV_W-1:0] clkDiv;
  logic [`DL_TO_W-1:0]  ackTimeoutValue;
  logic [7:0]           userAddr, userWData, userRdData, tgtMode, rd;
  logic [1:0]           receivedParity;
  logic [7:0]           pat [4] = '{8'h00, 8'h5a, 8'ha7, 8'hff};
  int                   err_count = 0, check_count = 0, cyc = 0, n;

  dl_link_if lk ();
  dl_initiator dl_initiator_i (.clk, .rst, .link(lk), .linkEnable, .linkIrqEnable, .stopClockOff, .clkDiv,
    .ackTimeoutValue, .stopReq, .stopped, .userReqValid, .userWrite, .userAddr, .userWData, .userReady,
    .userDone, .userDoneErr, .userRdData, .errClear, .globalErrorFlag, .timeoutErrorFlag, .parityErrorFlag,
    .targetErrorFlag, .cancelFlag, .receivedParity, .targetIrqLevel, .gpioMode, .targetIrqSignal, .linkErrorIrq);
  dl_target dl_target_i (.link(lk), .tgtNoAck, .tgtErrInject, .tgtParFlip, .tgtIrqRaise, .tgtWake,
    .tgtLowPower, .tgtMode);
  dl_chk dl_chk_i (.clk, .rst, .linkClk(lk.linkClk), .reqValid(lk.reqValid), .reqAddr(lk.reqAddr),
    .reqData(lk.reqData), .ackValid(lk.ackValid), .ackData(lk.ackData), .ackParity(lk.ackParity),
    .irqLine(lk.irqLine), .linkEnable, .linkIrqEnable, .stopClockOff, .errClear, .userDone, .userDoneErr,
    .stopped, .globalErrorFlag, .timeoutErrorFlag, .parityErrorFlag, .targetErrorFlag, .receivedParity,
    .targetIrqLevel, .targetIrqSignal, .linkErrorIrq, .gpioMode);

  // Bus clock, 20 ns
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard: the whole sequence needs about a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      results();
    end
  end

  // *************
  // Shared tasks
  // *************
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always move 1 ns after the edge
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] flg();
    return {3'h0, cancelFlag, globalErrorFlag, timeoutErrorFlag, parityErrorFlag, targetErrorFlag};
  endfunction

  // Even and odd bit positions, worked out independently of the design
  function automatic logic [1:0] par(input logic [7:0] d);
    return {^(d & 8'haa), ^(d & 8'h55)};
  endfunction

  // One edge passes first so valid is never dropped and raised in one step
  task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
    tick(1);
    for (n = 0; n < 400 && userReady !== 1'b1; n++) tick(1);
    // A slot that never frees counts as a mismatch
    if (userReady !== 1'b1)
      err_count++;
    userReqValid = 1'b1;
    userWrite = w;
    userAddr = a;
    userWData = d;
    tick(1);
    userReqValid = 1'b0;
  endtask

  task automatic wt();
    for (n = 0; n < 400 && userDone !== 1'b1; n++) tick(1);
    // A lost answer counts as a mismatch even if stale values happen to match
    if (userDone !== 1'b1)
      err_count++;
    dErr = userDoneErr;
    rd = userRdData;
  endtask

  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
    req(w, a, d);
    wt();
  endtask

  task automatic clr();
    errClear = 1'b1;
    tick(1);
    errClear = 1'b0;
    tick(2);
  endtask

  // *********
  // Sequence
  // *********
  initial
  begin
    {rst, linkEnable, linkIrqEnable, stopClockOff, stopReq, userReqValid, userWrite, errClear} = 8'h80;
    {tgtNoAck, tgtErrInject, tgtParFlip, tgtIrqRaise, tgtWake} = 5'h00;
    {userAddr, userWData} = 16'h0000;
    clkDiv = 4'h1;
    ackTimeoutValue = 16'h00c8;
    repeat (10) @(posedge clk);
    #1;
    rst = 1'b0;
    tick(3);
    chk({7'h00, gpioMode}, 8'h01);
    chk(flg(), 8'h00);
    linkEnable = 1'b1;
    tick(60);
    // Write then read back each pattern
    for (int i = 0; i < 4; i++)
    begin
      xf(1'b1, 8'(i), pat[i]);
      xf(1'b0, 8'(i), 8'h00);
      chk({dErr, rd}, {1'b0, pat[i]});
      chk({6'h00, receivedParity}, {6'h00, par(pat[i])});
    end
    // Target error, then a transfer that must be replaced by idle
    linkIrqEnable = 1'b1;
    tgtErrInject = 1'b1;
    tick(20);
    xf(1'b1, 8'h20, 8'h11);
    tick(2);
    chk({dErr, flg(), linkErrorIrq}, {1'b1, 8'h09, 1'b1});
    tgtErrInject = 1'b0;
    tick(20);
    xf(1'b0, 8'h01, 8'h00);
    // Data buffer keeps the failing write's echo for later inspection
    chk({dErr, rd}, {1'b1, 8'h11});
    chk(flg(), 8'h09);
    clr();
    chk({flg(), linkErrorIrq}, 9'h000);
    // Corrupted parity on the answer
    tgtParFlip = 1'b1;
    tick(20);
    xf(1'b1, 8'h30, 8'h3c);
    chk({flg(), receivedParity}, {8'h0a, ~par(8'h3c)});
    tgtParFlip = 1'b0;
    clr();
    // Missing answer with a second transfer queued behind it
    tgtNoAck = 1'b1;
    tick(20);
    req(1'b1, 8'h40, 8'h01);
    req(1'b1, 8'h41, 8'h02);
    wt();
    tick(5);
    chk({dErr, flg()}, {1'b1, 8'h1c});
    tgtNoAck = 1'b0;
    tick(20);
    clr();
    // Level interrupt from the target, cleared only at the target
    tgtIrqRaise = 1'b1;
    tick(20);
    chk({6'h00, targetIrqLevel, targetIrqSignal}, 8'h03);
    tgtIrqRaise = 1'b0;
    tick(20);
    chk({6'h00, targetIrqLevel, targetIrqSignal}, 8'h03);
    xf(1'b1, `DL_TGT_IRQCLR_ADDR, 8'h01);
    tick(20);
    chk({6'h00, targetIrqLevel, targetIrqSignal}, 8'h00);
    // Mode write still in flight when stop is requested
    req(1'b1, `DL_TGT_MODE_ADDR, 8'h02);
    stopClockOff = 1'b1;
    stopReq = 1'b1;
    wt();
    chk({dErr, stopped, tgtMode}, {2'b00, 8'h02});
    for (n = 0; n < 200 && stopped !== 1'b1; n++) tick(1);
    tick(10);
    repeat (20)
    begin
      tick(1);
      chk({6'h00, lk.linkClk, tgtLowPower}, 8'h01);
    end
    // Wake needs the link clock back
    stopReq = 1'b0;
    tgtWake = 1'b1;
    tick(40);
    chk({6'h00, tgtLowPower, targetIrqLevel}, 8'h01);
    tgtWake = 1'b0;
    stopClockOff = 1'b0;
    // Reset in the middle of a stuck transfer
    tgtNoAck = 1'b1;
    tick(20);
    req(1'b0, 8'h00, 8'h00);
    tick(10);
    rst = 1'b1;
    linkEnable = 1'b0;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk({5'h00, gpioMode, userReady, lk.reqValid}, 8'h04);
    chk(flg(), 8'h00);
    results();
  end
endmodule
`default_nettype wire
